/* ncd_buf.sv */
`default_nettype none
// ==========================================================
// two-entry buffer, head entry drives the outputs directly
module ncd_buf #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] head_q, head_d, spare_q, spare_d;
  logic [1:0] cnt_q, cnt_d;
  logic full_q, full_d, valid_q, valid_d;
  logic push, pop;

  assign in_ready = ~full_q;
  assign out_valid = valid_q;
  assign out_data = head_q;
  assign push = in_valid & ~full_q;
  assign pop = valid_q & out_ready;

  // next entries and occupancy
  always_comb begin
    head_d = head_q;
    spare_d = spare_q;
    cnt_d = cnt_q;
    case (cnt_q)
      2'h0: begin
        if (push) begin
          head_d = in_data;
          cnt_d = 2'h1;
        end
      end
      2'h1: begin
        if (push && pop) begin
          head_d = in_data;
        end else if (push) begin
          spare_d = in_data;
          cnt_d = 2'h2;
        end else if (pop) begin
          cnt_d = 2'h0;
        end
      end
      2'h2: begin
        // full: no push possible, drain spare into head
        if (pop) begin
          head_d = spare_q;
          cnt_d = 2'h1;
        end
      end
      default: cnt_d = 2'h0;
    endcase
    full_d = (cnt_d == 2'h2);
    valid_d = (cnt_d != 2'h0);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      head_q <= '0;
      spare_q <= '0;
      cnt_q <= 2'h0;
      full_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      head_q <= head_d;
      spare_q <= spare_d;
      cnt_q <= cnt_d;
      full_q <= full_d;
      valid_q <= valid_d;
    end
  end
endmodule
`default_nettype wire

/* ncd_nco_sync_second_order_comb_decimator.sv */
`default_nettype none
// Notes on behaviour
// - master-select set: drive sync pulse on sync pin at rising clock edge.
// - master-select clear: sync pin is an input sampled every rising edge.
// - slave holds oscillator without advance while sync input stays high.
// - 32-bit sync window mask register controls synchronisation precision.
// - master pulses when sine lies in mask window around zero crossing, or on a tuning access.
// - slave aligns the masked most-significant phase bits to the master.
// - fractional single real mode: advance phase each edge strobe is high.
// - master forces internal sync on any tuning register write or read.
// - slave generates no internal sync on tuning access, phase continuous.
// - back to master after retune: sync at next zero phase passage.
// - decimator accepts samples at full input rate in every mode.
// - one output per ratio input samples, ratio one to sixteen.
// - I and Q filtered in parallel, then time-multiplexed on one path.
// - response is squared comb-integrator, scaled by two to scale plus two.
// - scale factor zero to six, each step six dB more attenuation.
// - scale factor still applied when ratio one bypasses the stage.
// - diversity mode per-channel rate up to half single-channel maximum.
// - both diversity channels mixed with identical oscillator words.
module ncd_nco_sync_second_order_comb_decimator (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [9:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic frac_timing_mode,
  input wire logic channel_select,
  input wire logic phase_align_pin_i,
  output logic phase_align_pin_o,
  output logic phase_align_pin_oe_b,
  output logic [31:0] nco_phase,
  input wire logic in_valid,
  input wire ncd_pkg::ncd_iq_t in_sample,
  output logic out_valid,
  input wire logic out_ready,
  output ncd_pkg::ncd_word_t out_word
);
  // ==========================================================
  // control registers
  logic [31:0] ctrl_q, ctrl_d, mask_q, mask_d, tune_q, tune_d, rdata_q, rdata_d;
  logic [4:0] ratio_q, ratio_d;
  logic [2:0] scale_q, scale_d;
  logic tune_access, master;
  assign master = ctrl_q[ncd_pkg::SYNC_MASTER_BIT];
  assign tune_access = (reg_wr || reg_rd) && (reg_addr == ncd_pkg::OFS_TUNING);
  assign reg_rdata = rdata_q;
  // writes, read mux; unmapped offsets read zero
  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    tune_d = tune_q;
    ratio_d = ratio_q;
    scale_d = scale_q;
    rdata_d = rdata_q;
    if (reg_wr) begin
      case (reg_addr)
        ncd_pkg::OFS_SYNC_CTRL: ctrl_d = reg_wdata;
        ncd_pkg::OFS_SYNC_WINDOW_MASK: mask_d = reg_wdata;
        ncd_pkg::OFS_TUNING: tune_d = reg_wdata;
        ncd_pkg::OFS_DECIM_CTRL: begin
          ratio_d = reg_wdata[ncd_pkg::RATIO_LSB +: ncd_pkg::RATIO_W];
          scale_d = reg_wdata[ncd_pkg::SCALE_LSB +: ncd_pkg::SCALE_W];
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ncd_pkg::OFS_SYNC_CTRL: rdata_d = ctrl_q;
        ncd_pkg::OFS_SYNC_WINDOW_MASK: rdata_d = mask_q;
        ncd_pkg::OFS_TUNING: rdata_d = tune_q;
        ncd_pkg::OFS_DECIM_CTRL: begin
          rdata_d = 32'h0;
          rdata_d[ncd_pkg::RATIO_LSB +: ncd_pkg::RATIO_W] = ratio_q;
          rdata_d[ncd_pkg::SCALE_LSB +: ncd_pkg::SCALE_W] = scale_q;
        end
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_q <= ncd_pkg::SYNC_CTRL_RST;
      mask_q <= ncd_pkg::SYNC_WINDOW_MASK_RST;
      tune_q <= ncd_pkg::TUNING_RST;
      ratio_q <= ncd_pkg::RATIO_RST;
      scale_q <= ncd_pkg::SCALE_RST;
      rdata_q <= 32'h0;
    end else begin
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
      tune_q <= tune_d;
      ratio_q <= ratio_d;
      scale_q <= scale_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // pin synchronisers, first stage read only by the second
  logic sync_m_q, sync_s_q, ab_m_q, ab_s_q;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync_m_q <= 1'b0;
      sync_s_q <= 1'b0;
      ab_m_q <= 1'b0;
      ab_s_q <= 1'b0;
    end else begin
      sync_m_q <= phase_align_pin_i;
      sync_s_q <= sync_m_q;
      ab_m_q <= channel_select;
      ab_s_q <= ab_m_q;
    end
  end

  // ==========================================================
  // oscillator phase and sync pin
  logic [31:0] phase_q, phase_d, phase_adv;
  logic pin_o_q, pin_o_d, pin_oe_b_q, pin_oe_b_d, advance, crossing;
  assign phase_adv = phase_q + tune_q;
  assign phase_align_pin_o = pin_o_q;
  assign phase_align_pin_oe_b = pin_oe_b_q;
  assign nco_phase = phase_q;
  // one shared phase word for both channels
  always_comb begin
    // fractional timing steps on strobe level, else on each sample
    advance = frac_timing_mode ? ab_s_q : in_valid;
    // masked phase wrapped past zero during this step
    crossing = advance && ((phase_adv & mask_q) < (phase_q & mask_q));
    phase_d = phase_q;
    pin_o_d = 1'b0;
    // drive pin while master; release it as slave
    pin_oe_b_d = ~master;
    if (master) begin
      if (tune_access) begin
        // tuning access forces an internal sync
        phase_d = 32'h0;
        pin_o_d = 1'b1;
      end else begin
        if (advance) begin
          phase_d = phase_adv;
        end
        // after retune, pulse at next zero passage
        pin_o_d = crossing;
      end
    end else if (sync_s_q) begin
      // hold oscillator while sync stays high
      // align masked msbs to the master's zero phase
      phase_d = phase_q & ~mask_q;
    end else if (advance) begin
      // slave keeps phase on tuning access
      phase_d = phase_adv;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      phase_q <= 32'h0;
      pin_o_q <= 1'b0;
      pin_oe_b_q <= 1'b1;
    end else begin
      phase_q <= phase_d;
      pin_o_q <= pin_o_d;
      pin_oe_b_q <= pin_oe_b_d;
    end
  end

  // ==========================================================
  // second order comb decimator
  localparam int EXT_W = ncd_pkg::ACC_W - ncd_pkg::SAMPLE_W;
  // shift down by scale plus base, keep output width
  function automatic logic [ncd_pkg::OUT_W-1:0] cic_scale(
    input logic signed [ncd_pkg::ACC_W-1:0] v,
    input logic [2:0] s
  );
    logic signed [ncd_pkg::ACC_W-1:0] t;
    t = v >>> ({1'b0, s} + ncd_pkg::SCALE_BASE_SHIFT);
    return t[ncd_pkg::OUT_W-1:0];
  endfunction
  // out-of-range settings clamp to the nearest legal value
  function automatic logic [4:0] clamp_ratio(input logic [4:0] r);
    return (r < ncd_pkg::RATIO_MIN) ? ncd_pkg::RATIO_MIN :
      ((r > ncd_pkg::RATIO_MAX) ? ncd_pkg::RATIO_MAX : r);
  endfunction
  logic signed [ncd_pkg::ACC_W-1:0] xi, xq;
  logic signed [ncd_pkg::ACC_W-1:0] i1_q, i1_d, i2_q, i2_d, q1_q, q1_d, q2_q, q2_d;
  logic signed [ncd_pkg::ACC_W-1:0] di1_q, di1_d, di2_q, di2_d, dq1_q, dq1_d, dq2_q, dq2_d;
  logic signed [ncd_pkg::ACC_W-1:0] ci1, ci2, cq1, cq2;
  logic [4:0] cnt_q, cnt_d, ratio_eff;
  logic [2:0] scale_eff;
  logic fire;
  assign xi = {{EXT_W{in_sample.i[ncd_pkg::SAMPLE_W-1]}}, in_sample.i};
  assign xq = {{EXT_W{in_sample.q[ncd_pkg::SAMPLE_W-1]}}, in_sample.q};
  assign ratio_eff = clamp_ratio(ratio_q);
  assign scale_eff = (scale_q > ncd_pkg::SCALE_MAX) ? ncd_pkg::SCALE_MAX : scale_q;
  // one sample per clock accepted, no stall on the input
  // I and Q run in parallel integrator/comb pairs
  always_comb begin
    i1_d = i1_q;
    i2_d = i2_q;
    q1_d = q1_q;
    q2_d = q2_q;
    di1_d = di1_q;
    di2_d = di2_q;
    dq1_d = dq1_q;
    dq2_d = dq2_q;
    cnt_d = cnt_q;
    fire = 1'b0;
    // wrap-around sums, width covers ratio squared growth
    ci1 = i2_q + i1_q + xi - di1_q;
    ci2 = ci1 - di2_q;
    cq1 = q2_q + q1_q + xq - dq1_q;
    cq2 = cq1 - dq2_q;
    if (in_valid) begin
      i1_d = i1_q + xi;
      i2_d = i2_q + i1_d;
      q1_d = q1_q + xq;
      q2_d = q2_q + q1_d;
      // one output every ratio input samples
      if (cnt_q >= ratio_eff - 5'h01) begin
        cnt_d = 5'h00;
        fire = 1'b1;
        // two comb sections with ratio delay
        di1_d = i2_d;
        di2_d = ci1;
        dq1_d = q2_d;
        dq2_d = cq1;
      end else begin
        cnt_d = cnt_q + 5'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      i1_q <= '0;
      i2_q <= '0;
      q1_q <= '0;
      q2_q <= '0;
      di1_q <= '0;
      di2_q <= '0;
      dq1_q <= '0;
      dq2_q <= '0;
      cnt_q <= 5'h00;
    end else begin
      i1_q <= i1_d;
      i2_q <= i2_d;
      q1_q <= q1_d;
      q2_q <= q2_d;
      di1_q <= di1_d;
      di2_q <= di2_d;
      dq1_q <= dq1_d;
      dq2_q <= dq2_d;
      cnt_q <= cnt_d;
    end
  end

  // ==========================================================
  // shared output path: I word then Q word into the buffer
  typedef enum logic [1:0] {MUX_IDLE, MUX_SEND_I, MUX_SEND_Q} ncd_mux_t;
  ncd_mux_t mux_q, mux_d;
  logic [ncd_pkg::OUT_W-1:0] oi_q, oi_d, oq_q, oq_d;
  ncd_pkg::ncd_word_t buf_in;
  logic buf_in_valid, buf_in_ready;
  // a new pair arriving before Q leaves replaces the pending pair
  always_comb begin
    mux_d = mux_q;
    oi_d = oi_q;
    oq_d = oq_q;
    buf_in_valid = 1'b0;
    buf_in.is_q = 1'b0;
    buf_in.data = oi_q;
    case (mux_q)
      MUX_IDLE: ;
      MUX_SEND_I: begin
        buf_in_valid = 1'b1;
        if (buf_in_ready) begin
          mux_d = MUX_SEND_Q;
        end
      end
      MUX_SEND_Q: begin
        buf_in_valid = 1'b1;
        buf_in.is_q = 1'b1;
        buf_in.data = oq_q;
        if (buf_in_ready) begin
          mux_d = MUX_IDLE;
        end
      end
      default: mux_d = MUX_IDLE;
    endcase
    if (fire) begin
      // clamped scale; applied also at ratio one
      oi_d = cic_scale(ci2, scale_eff);
      oq_d = cic_scale(cq2, scale_eff);
      mux_d = MUX_SEND_I;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mux_q <= MUX_IDLE;
      oi_q <= '0;
      oq_q <= '0;
    end else begin
      mux_q <= mux_d;
      oi_q <= oi_d;
      oq_q <= oq_d;
    end
  end
  ncd_buf #(
    .W($bits(ncd_pkg::ncd_word_t))
  ) u_buf (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_word)
  );
endmodule
`default_nettype wire

/* ncd_nco_sync_second_order_comb_decimator_assertions.sv */
`default_nettype none
// ====
// port checks, sync pin and decimator stream
module ncd_nco_sync_second_order_comb_decimator_assertions (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [9:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic phase_align_pin_i,
  input wire logic phase_align_pin_o,
  input wire logic phase_align_pin_oe_b,
  input wire logic [31:0] nco_phase,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire ncd_pkg::ncd_word_t out_word
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // control and tuning accesses
  wire ctl_wr = reg_wr && reg_addr == ncd_pkg::OFS_SYNC_CTRL;
  wire tun_acc = (reg_wr || reg_rd) && reg_addr == ncd_pkg::OFS_TUNING;
  AST_OE_ON: assert property (ctl_wr && reg_wdata[3] |-> ##[1:3] !phase_align_pin_oe_b)
    else $error("pin not driven after master select");
  AST_OE_OFF: assert property (ctl_wr && !reg_wdata[3] |-> ##[1:3] phase_align_pin_oe_b)
    else $error("pin still driven after slave select");
  AST_PULSE: assert property ($rose(phase_align_pin_o) |=> !phase_align_pin_o)
    else $error("sync pulse longer than one cycle");
  AST_TUNE: assert property (tun_acc && !phase_align_pin_oe_b |-> ##[1:2] phase_align_pin_o)
    else $error("no sync pulse after tuning access as master");
  AST_QUIET: assert property (phase_align_pin_oe_b [*3] |-> !phase_align_pin_o)
    else $error("sync pulse while slave");
  AST_HOLD: assert property ((phase_align_pin_oe_b && phase_align_pin_i) [*4] |=>
    $stable(nco_phase))
    else $error("phase moved while sync input held");
  AST_STALL: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
    else $error("output word changed while stalled");
  AST_Q_NEXT: assert property (out_valid && out_ready && !out_word.is_q |->
    ##[1:3] out_valid && out_word.is_q)
    else $error("q word did not follow i word");
  AST_I_FIRST: assert property ($rose(out_valid) |-> !out_word.is_q)
    else $error("output burst began with q word");
  AST_RST: assert property (@(posedge clk) disable iff (1'b0) !rst_b |=> !out_valid &&
    phase_align_pin_oe_b && !phase_align_pin_o && nco_phase == 32'h0)
    else $error("outputs not at reset values");
endmodule
bind ncd_nco_sync_second_order_comb_decimator ncd_nco_sync_second_order_comb_decimator_assertions u_chk (.clk, .rst_b, .reg_addr, .reg_wr,
  .reg_rd, .reg_wdata, .phase_align_pin_i, .phase_align_pin_o, .phase_align_pin_oe_b,
  .nco_phase, .out_valid, .out_ready, .out_word);
`default_nettype wire

/* ncd_pkg.sv */
`default_nettype none
package ncd_pkg;
  // ==========================================================
  // register offsets, word addresses on the control port
  localparam logic [9:0] OFS_SYNC_CTRL = 10'h300;
  localparam logic [9:0] OFS_SYNC_WINDOW_MASK = 10'h302;
  localparam logic [9:0] OFS_TUNING = 10'h303;
  localparam logic [9:0] OFS_DECIM_CTRL = 10'h305;

  // ==========================================================
  // field positions
  localparam int SYNC_MASTER_BIT = 3;
  localparam int RATIO_LSB = 0;
  localparam int RATIO_W = 5;
  localparam int SCALE_LSB = 8;
  localparam int SCALE_W = 3;

  // ==========================================================
  // reset values and limits
  localparam logic [31:0] SYNC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SYNC_WINDOW_MASK_RST = 32'hffff_ffff;
  localparam logic [31:0] TUNING_RST = 32'h0000_0000;
  localparam logic [4:0] RATIO_RST = 5'h01;
  localparam logic [4:0] RATIO_MIN = 5'h01;
  localparam logic [4:0] RATIO_MAX = 5'h10;
  localparam logic [2:0] SCALE_RST = 3'h0;
  localparam logic [2:0] SCALE_MAX = 3'h6;
  localparam logic [3:0] SCALE_BASE_SHIFT = 4'h2;

  // ==========================================================
  // data widths
  localparam int SAMPLE_W = 16;
  localparam int ACC_W = 24;
  localparam int OUT_W = 22;

  // one translated complex input sample
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] i;
    logic signed [SAMPLE_W-1:0] q;
  } ncd_iq_t;

  // one word of the shared output path
  typedef struct packed {
    logic is_q;
    logic signed [OUT_W-1:0] data;
  } ncd_word_t;
endpackage
`default_nettype wire

/* ncd_sync_peer.sv */
`default_nettype none
// ====
// far end of the sync pin: another receiver or a system sync source
module ncd_sync_peer (
  input wire logic clk,
  input wire logic dev_o,
  input wire logic dev_oe_b,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv = 1'b0;
  // resolved wire, peer sits low when idle like a pull-down
  assign pin = dev_oe_b ? drv : dev_o;
  task automatic hold(input int n);
    @(posedge clk);
    #1 drv = 1'b1;
    repeat (n) @(posedge clk);
    #1 drv = 1'b0;
    @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

/* tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, reg_wr, reg_rd, frac_timing_mode, channel_select, in_valid;
  logic out_ready, pin, pin_o, pin_oe_b, out_valid, want_q;
  logic [9:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, nco_phase;
  logic [21:0] last_i, last_q, ei, eq;
  ncd_pkg::ncd_iq_t in_sample;
  ncd_pkg::ncd_word_t out_word;
  int mismatches, num_checks, n_i, n_q, pulses, m, s, v;
  logic [4:0] m_tab [6] = '{5'h01, 5'h01, 5'h04, 5'h10, 5'h05, 5'h00};
  logic [2:0] s_tab [6] = '{3'h0, 3'h3, 3'h2, 3'h6, 3'h0, 3'h7};
  int nw_tab [6] = '{2, 2, 1, 2, 2, 1};
  bit fast_tab [6] = '{0, 0, 1, 1, 0, 0};
  ncd_nco_sync_second_order_comb_decimator uut (.clk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .frac_timing_mode, .channel_select, .phase_align_pin_i(pin), .phase_align_pin_o(pin_o),
    .phase_align_pin_oe_b(pin_oe_b), .nco_phase, .in_valid, .in_sample, .out_valid,
    .out_ready, .out_word);
  ncd_sync_peer peer (.clk, .dev_o(pin_o), .dev_oe_b(pin_oe_b), .pin);
  // ====
  // clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ====
  // access tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    tick(1);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
  endtask
  task automatic rdc(input logic [9:0] a, input logic [31:0] e);
    tick(1);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    chk(reg_rdata, e);
  endtask
  // samples spaced two cycles apart unless fast
  task automatic adv(input int n, input bit fast);
    repeat (n) begin
      tick(1);
      in_valid = 1'b1;
      if (!fast) begin
        tick(1);
        in_valid = 1'b0;
      end
    end
    tick(1);
    in_valid = 1'b0;
  endtask
  task automatic endt(input string n);
    $display("test %s done", n);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ====
  // output monitor at the falling edge, where launched values have settled
  always @(negedge clk) begin
    if (pin_o === 1'b1) pulses++;
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      chk(32'(out_word.is_q), 32'(want_q));
      want_q = !want_q;
      if (out_word.is_q) begin
        n_q++;
        last_q = out_word.data;
      end else begin
        n_i++;
        last_i = out_word.data;
      end
    end
  end
  // about 450 cycles needed, over forty times allowed
  initial begin
    #(40 * 20000);
    mismatches++;
    close_out();
  end
  // ====
  // tests
  initial begin
    {rst_b, reg_wr, reg_rd, frac_timing_mode, channel_select, in_valid, want_q} = '0;
    out_ready = 1'b1;
    reg_addr = 10'h000;
    reg_wdata = 32'h0;
    in_sample = 32'h0;
    tick(5);
    rst_b = 1'b1;
    chk(32'(pin_oe_b), 32'h1);
    rdc(ncd_pkg::OFS_SYNC_WINDOW_MASK, 32'hffff_ffff);
    rdc(ncd_pkg::OFS_SYNC_CTRL, 32'h0);
    rdc(10'h3ff, 32'h0);
    wr(ncd_pkg::OFS_DECIM_CTRL, 32'h0000_0610);
    rdc(ncd_pkg::OFS_DECIM_CTRL, 32'h0000_0610);
    endt("registers");
    wr(ncd_pkg::OFS_TUNING, 32'h0000_0013);
    adv(5, 0);
    rdc(ncd_pkg::OFS_TUNING, 32'h0000_0013);
    chk(nco_phase, 32'h0000_005f);
    endt("slave tuning");
    wr(ncd_pkg::OFS_SYNC_WINDOW_MASK, 32'hffff_fff0);
    fork
      peer.hold(8);
      begin
        tick(3);
        adv(2, 0);
      end
    join
    chk(nco_phase, 32'h0000_000f);
    tick(2);
    adv(1, 0);
    chk(nco_phase, 32'h0000_0022);
    wr(ncd_pkg::OFS_SYNC_WINDOW_MASK, 32'hffff_ffff);
    peer.hold(2);
    tick(3);
    chk(nco_phase, 32'h0);
    endt("slave sync");
    wr(ncd_pkg::OFS_TUNING, 32'h4000_0000);
    wr(ncd_pkg::OFS_SYNC_CTRL, 32'h0000_0008);
    tick(2);
    chk(32'(pin_oe_b), 32'h0);
    adv(3, 0);
    chk(nco_phase, 32'hc000_0000);
    chk(32'(pulses), 32'h0);
    adv(1, 0);
    tick(2);
    chk(32'(pulses), 32'h1);
    adv(1, 0);
    rdc(ncd_pkg::OFS_TUNING, 32'h4000_0000);
    tick(2);
    chk(32'(pulses), 32'h2);
    chk(nco_phase, 32'h0);
    wr(ncd_pkg::OFS_SYNC_CTRL, 32'h0);
    endt("master sync");
    wr(ncd_pkg::OFS_TUNING, 32'h0000_0010);
    frac_timing_mode = 1'b1;
    channel_select = 1'b1;
    tick(3);
    channel_select = 1'b0;
    tick(4);
    chk(nco_phase, 32'h0000_0030);
    channel_select = 1'b1;
    tick(1);
    channel_select = 1'b0;
    tick(4);
    chk(nco_phase, 32'h0000_0040);
    frac_timing_mode = 1'b0;
    endt("fractional advance");
    in_sample = {16'h03e8, 16'hfc18};
    foreach (m_tab[k]) begin
      wr(ncd_pkg::OFS_DECIM_CTRL, {21'h0, s_tab[k], 3'h0, m_tab[k]});
      m = (m_tab[k] == 0) ? 1 : int'(m_tab[k]);
      s = (s_tab[k] > 6) ? 6 : int'(s_tab[k]);
      v = 1000 * m * m;
      ei = 22'(v >>> (s + 2));
      eq = 22'((-v) >>> (s + 2));
      adv(3 * m, fast_tab[k]);
      tick(8);
      n_i = 0;
      n_q = 0;
      out_ready = (k != 2);
      adv(nw_tab[k] * m, fast_tab[k]);
      tick(8);
      out_ready = 1'b1;
      tick(8);
      chk(32'(n_i), 32'(nw_tab[k]));
      chk(32'(n_q), 32'(nw_tab[k]));
      chk(32'(last_i), 32'(ei));
      chk(32'(last_q), 32'(eq));
    end
    endt("decimator");
    close_out();
  end
endmodule
`default_nettype wire
